// >>> tb/ccrb_host_model.sv
// ====================================================
// Host that drives the two-wire register bus
module ccrb_host_model #(
  parameter logic [6:0] ADDR = 7'h35
) (
  clk_sys,
  sda_oe,
  sda_out,
  scl_in,
  sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  input wire logic clk_sys;
  input wire logic sda_oe;
  input wire logic sda_out;
  output logic scl_in;
  output logic sda_in;
  logic low;
  initial begin
    scl_in = 1'b1;
    low = 1'b0;
  end
  // Open-drain data line with pull-up
  assign sda_in = ~(low | (sda_oe & ~sda_out));
  task automatic tk(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic put(logic b);
    low <= ~b;
    tk(5);
    scl_in <= 1'b1;
    tk(6);
    scl_in <= 1'b0;
    tk(3);
  endtask
  task automatic get(output logic b);
    low <= 1'b0;
    tk(5);
    scl_in <= 1'b1;
    tk(4);
    b = sda_in;
    tk(2);
    scl_in <= 1'b0;
    tk(3);
  endtask
  task automatic start();
    low <= 1'b0;
    tk(3);
    scl_in <= 1'b1;
    tk(6);
    low <= 1'b1;
    tk(6);
    scl_in <= 1'b0;
    tk(3);
  endtask
  task automatic stop();
    low <= 1'b1;
    tk(3);
    scl_in <= 1'b1;
    tk(6);
    low <= 1'b0;
    tk(6);
  endtask
  task automatic put_byte(logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(a);
    ack = ~a;
  endtask
  task automatic wr(logic [6:0] adr, logic [7:0] ofs, logic [7:0] v,
                    output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({adr, 1'b0}, a0);
    put_byte(ofs, a1);
    put_byte(v, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(logic [7:0] ofs, output logic [7:0] v);
    logic a;
    start();
    put_byte({ADDR, 1'b0}, a);
    put_byte(ofs, a);
    start();
    put_byte({ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      get(a);
      v[i] = a;
    end
    put(1'b1);
    stop();
  endtask
endmodule

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ccrb_pkg::*;
  typedef struct {logic [7:0] ofs; logic [7:0] wr; logic [7:0] rd;} ccrb_row_t;
  logic clk_sys, rst_b, scl_in, sda_in, sda_out, sda_oe;
  logic reg_reset_cmd, pulse_seq_done, pulse_ctrl_enable, charge_enable;
  logic [6:0] fast_charge_current;
  logic [3:0] precharge_current, termination_current;
  logic [5:0] charge_voltage_limit;
  logic precharge_to_fast_threshold, recharge_offset, termination_enable;
  logic status_pin_disable, safety_timer_enable, pulse_voltage_up;
  logic [1:0] host_timeout_sel, fast_charge_time_limit;
  logic pulse_voltage_down, timeout_kick, timeout_expired, ok, kick_seen;
  logic [7:0] d;
  int fails = 0;
  int cmp_count = 0;
  int n;
  ccrb_row_t rows[9] = '{'{8'h04, 8'h55, 8'h4f}, '{8'h04, 8'h80, 8'h80},
    '{8'h04, 8'h4f, 8'h4f}, '{8'h05, 8'ha6, 8'ha6}, '{8'h06, 8'hfd, 8'hc1},
    '{8'h06, 8'hc2, 8'hc2}, '{8'h07, 8'h4a, 8'h4b}, '{8'h07, 8'h02, 8'h03},
    '{8'h08, 8'h5a, 8'h00}};
  ccrb_charge_config #(.TMO_BASE_CYCLES(40'd3000)) i_dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .reg_reset_cmd(reg_reset_cmd),
    .pulse_seq_done(pulse_seq_done), .pulse_ctrl_enable(pulse_ctrl_enable),
    .fast_charge_current(fast_charge_current), .charge_enable(charge_enable),
    .precharge_current(precharge_current),
    .termination_current(termination_current),
    .charge_voltage_limit(charge_voltage_limit),
    .precharge_to_fast_threshold(precharge_to_fast_threshold),
    .recharge_offset(recharge_offset),
    .termination_enable(termination_enable),
    .status_pin_disable(status_pin_disable),
    .host_timeout_sel(host_timeout_sel),
    .safety_timer_enable(safety_timer_enable),
    .fast_charge_time_limit(fast_charge_time_limit),
    .pulse_voltage_up(pulse_voltage_up),
    .pulse_voltage_down(pulse_voltage_down), .timeout_kick(timeout_kick),
    .timeout_expired(timeout_expired));
  ccrb_host_model i_host (.clk_sys(clk_sys), .sda_oe(sda_oe),
    .sda_out(sda_out), .scl_in(scl_in), .sda_in(sda_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (timeout_kick === 1'b1) kick_seen <= 1'b1;
  end
  function automatic logic [7:0] view(logic [7:0] ofs);
    case (ofs)
      8'h04: return {pulse_ctrl_enable, fast_charge_current};
      8'h05: return {precharge_current, termination_current};
      8'h06: return {charge_voltage_limit, precharge_to_fast_threshold,
                     recharge_offset};
      8'h07: return {termination_enable, status_pin_disable,
                     host_timeout_sel, safety_timer_enable,
                     fast_charge_time_limit, 1'b1};
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_test(string name);
    $display("test %s done", name);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic pulse_in(bit to_reset);
    @(posedge clk_sys);
    if (to_reset) reg_reset_cmd <= 1'b1;
    else pulse_seq_done <= 1'b1;
    @(posedge clk_sys);
    reg_reset_cmd <= 1'b0;
    pulse_seq_done <= 1'b0;
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  initial begin
    rst_b = 1'b0;
    reg_reset_cmd = 1'b0;
    pulse_seq_done = 1'b0;
    kick_seen = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk_sys);
    check(view(8'h04), 8'h20);
    check(view(8'h05), 8'h13);
    check(view(8'h06), 8'h5e);
    check(view(8'h07), 8'h9d);
    check({7'h0, charge_enable}, 8'h01);
    i_host.rd(8'h07, d);
    check(d, 8'h9d);
    i_host.wr(7'h35, 8'h07, 8'h8d, ok);
    end_test("reset");
    foreach (rows[i]) begin
      i_host.wr(7'h35, rows[i].ofs, rows[i].wr, ok);
      check({7'h0, ok}, 8'h01);
      i_host.rd(rows[i].ofs, d);
      check(d, rows[i].rd);
      check(view(rows[i].ofs), rows[i].rd);
      if (rows[i].ofs == 8'h04)
        check({7'h0, charge_enable}, {7'h0, |rows[i].rd[6:0]});
    end
    end_test("table");
    i_host.wr(7'h35, 8'h09, 8'h03, ok);
    check({6'h0, pulse_voltage_up, pulse_voltage_down}, 8'h00);
    i_host.wr(7'h35, 8'h04, 8'h80, ok);
    i_host.wr(7'h35, 8'h09, 8'h02, ok);
    check({6'h0, pulse_voltage_up, pulse_voltage_down}, 8'h02);
    pulse_in(1'b0);
    check({6'h0, pulse_voltage_up, pulse_voltage_down}, 8'h00);
    end_test("pulse");
    i_host.wr(7'h12, 8'h04, 8'h33, ok);
    check({7'h0, ok}, 8'h00);
    check(view(8'h04), 8'h80);
    end_test("address");
    // Host restarts the timeout
    i_host.wr(7'h35, 8'h03, 8'h40, ok);
    check({7'h0, kick_seen}, 8'h01);
    i_host.rd(8'h03, d);
    check({7'h0, d[6]}, 8'h00);
    end_test("kick");
    i_host.wr(7'h35, 8'h05, 8'h77, ok);
    i_host.wr(7'h35, 8'h07, 8'h10, ok);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (timeout_expired !== 1'b1 && n < 4000);
    check({7'h0, timeout_expired}, 8'h01);
    check(view(8'h04), 8'h20);
    check(view(8'h05), 8'h13);
    check(view(8'h07), 8'h9d);
    end_test("timeout");
    // Longer periods: counter keeps its count across the select change
    for (int k = 2; k <= 3; k++) begin
      i_host.wr(7'h35, 8'h07, {2'h0, k[1:0], 4'h0}, ok);
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (timeout_expired !== 1'b1 && n < 13000);
      check({7'h0, timeout_expired}, 8'h01);
      check({7'h0, n > 3000 * (k - 1) && n <= 3000 << (k - 1)}, 8'h01);
    end
    end_test("periods");
    i_host.wr(7'h35, 8'h06, 8'h00, ok);
    check(view(8'h06), 8'h00);
    pulse_in(1'b1);
    check(view(8'h06), 8'h5e);
    end_test("regreset");
    // Second reset in mid-run
    i_host.wr(7'h35, 8'h05, 8'h77, ok);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk_sys);
    check(view(8'h05), 8'h13);
    check({7'h0, sda_oe}, 8'h00);
    end_test("rerun reset");
    close_out();
  end
  initial begin
    repeat (80000) @(posedge clk_sys);
    fails++;
    $display("mismatch at %0t: run did not finish", $time);
    close_out();
  end
endmodule

// >>> verilog/ccrb_charge_config.sv
`include "ccrb_params.svh"
module ccrb_charge_config #(
  parameter logic [6:0] DEV_ADDR = 7'h35, // Arbitrary bus address
  parameter logic [`CCRB_CNT_W-1:0] TMO_BASE_CYCLES =
    `CCRB_CNT_W'(`CCRB_TMO_BASE_S * 64'd`CCRB_CLK_HZ)
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic reg_reset_cmd,
  input wire logic pulse_seq_done,
  output logic pulse_ctrl_enable,
  output logic [6:0] fast_charge_current,
  output logic charge_enable,
  output logic [3:0] precharge_current,
  output logic [3:0] termination_current,
  output logic [5:0] charge_voltage_limit,
  output logic precharge_to_fast_threshold,
  output logic recharge_offset,
  output logic termination_enable,
  output logic status_pin_disable,
  output logic [1:0] host_timeout_sel,
  output logic safety_timer_enable,
  output logic [1:0] fast_charge_time_limit,
  output logic pulse_voltage_up,
  output logic pulse_voltage_down,
  output logic timeout_kick,
  output logic timeout_expired
);
  import ccrb_pkg::*;

  ccrb_regs_t r;
  ccrb_regs_t next_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic wr_now;
  logic [7:0] rd_byte;
  logic [`CCRB_CNT_W-1:0] tmo_limit;

  // =====================================================
  // Bus condition detection on synchronised lines
  assign scl_rise = r.scl_s2 & ~r.scl_s3;
  assign scl_fall = ~r.scl_s2 & r.scl_s3;
  assign start_det = r.scl_s2 & r.scl_s3 & ~r.sda_s2 & r.sda_s3;
  assign stop_det = r.scl_s2 & r.scl_s3 & r.sda_s2 & ~r.sda_s3;
  assign wr_now = scl_fall && r.st == CCRB_WDATA &&
                  r.bitcnt == `CCRB_BITS_PER_BYTE;

  // =====================================================
  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (r.ptr)
      `CCRB_OFS_KICK: rd_byte[`CCRB_KICK_BIT] = r.kick;
      `CCRB_OFS_CUR: rd_byte = r.cur;
      `CCRB_OFS_PRE: rd_byte = r.pre;
      `CCRB_OFS_VLT: rd_byte = r.vlt;
      `CCRB_OFS_TMR: rd_byte = r.tmr;
      `CCRB_OFS_PULSE: rd_byte = {6'h00, r.up, r.dn};
      default: rd_byte = 8'h00;
    endcase
  end

  // =====================================================
  // Host timeout limit
  always_comb begin
    unique case (r.tmr[`CCRB_TMO])
      2'h1: tmo_limit = TMO_BASE_CYCLES;
      2'h2: tmo_limit = TMO_BASE_CYCLES << 1;
      2'h3: tmo_limit = TMO_BASE_CYCLES << 2;
      default: tmo_limit = '0;
    endcase
  end

  // =====================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.scl_s1 = scl_in;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_s3 = r.scl_s2;
    next_r.sda_s1 = sda_in;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_s3 = r.sda_s2;
    next_r.expired = 1'b0;

    // Pulse requests end with their sequence
    if (pulse_seq_done) begin
      next_r.up = 1'b0;
      next_r.dn = 1'b0;
    end

    // Serial protocol engine
    if (start_det) begin
      next_r.st = CCRB_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (stop_det) begin
      next_r.st = CCRB_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (r.st)
        CCRB_ADDR, CCRB_REG, CCRB_WDATA: begin
          next_r.shift = {r.shift[6:0], r.sda_s2};
          next_r.bitcnt = r.bitcnt + 4'h1;
        end
        CCRB_RDATA_ACK: next_r.nack = r.sda_s2;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (r.st)
        CCRB_ADDR: begin
          if (r.bitcnt == `CCRB_BITS_PER_BYTE) begin
            if (r.shift[7:1] == DEV_ADDR) begin
              next_r.st = CCRB_ADDR_ACK;
              next_r.rw = r.shift[0];
              next_r.sda_oe = 1'b1;
            end else begin
              next_r.st = CCRB_IDLE;
            end
          end
        end
        CCRB_ADDR_ACK: begin
          if (r.rw) begin
            next_r.st = CCRB_RDATA;
            next_r.sda_oe = ~rd_byte[7];
            next_r.shift = {rd_byte[6:0], 1'b0};
            next_r.bitcnt = 4'h1;
          end else begin
            next_r.st = CCRB_REG;
            next_r.sda_oe = 1'b0;
            next_r.bitcnt = 4'h0;
          end
        end
        CCRB_REG: begin
          if (r.bitcnt == `CCRB_BITS_PER_BYTE) begin
            next_r.st = CCRB_REG_ACK;
            next_r.ptr = r.shift;
            next_r.sda_oe = 1'b1;
          end
        end
        CCRB_REG_ACK, CCRB_WDATA_ACK: begin
          next_r.st = CCRB_WDATA;
          next_r.sda_oe = 1'b0;
          next_r.bitcnt = 4'h0;
        end
        CCRB_WDATA: begin
          if (wr_now) begin
            next_r.st = CCRB_WDATA_ACK;
            next_r.ptr = r.ptr + 8'h01;
            next_r.sda_oe = 1'b1;
            unique case (r.ptr)
              `CCRB_OFS_KICK: next_r.kick = r.shift[`CCRB_KICK_BIT];
              `CCRB_OFS_CUR: begin
                next_r.cur[`CCRB_PEN_BIT] = r.shift[`CCRB_PEN_BIT];
                if (r.shift[`CCRB_FAST_CHARGE_CURRENT] > `CCRB_FAST_CHARGE_CURRENT_MAX) begin
                  next_r.cur[`CCRB_FAST_CHARGE_CURRENT] = `CCRB_FAST_CHARGE_CURRENT_MAX;
                end else begin
                  next_r.cur[`CCRB_FAST_CHARGE_CURRENT] = r.shift[`CCRB_FAST_CHARGE_CURRENT];
                end
              end
              `CCRB_OFS_PRE: next_r.pre = r.shift;
              `CCRB_OFS_VLT: begin
                next_r.vlt[1:0] = r.shift[1:0];
                if (r.shift[`CCRB_CHARGE_VOLTAGE_LIMIT] > `CCRB_CHARGE_VOLTAGE_LIMIT_MAX) begin
                  next_r.vlt[`CCRB_CHARGE_VOLTAGE_LIMIT] = `CCRB_CHARGE_VOLTAGE_LIMIT_MAX;
                end else begin
                  next_r.vlt[`CCRB_CHARGE_VOLTAGE_LIMIT] = r.shift[`CCRB_CHARGE_VOLTAGE_LIMIT];
                end
              end
              `CCRB_OFS_TMR: begin
                next_r.tmr = r.shift;
                next_r.tmr[`CCRB_RSVD_BIT] = 1'b1;
              end
              `CCRB_OFS_PULSE: begin
                if (r.cur[`CCRB_PEN_BIT]) begin
                  // A finished sequence stays cleared unless rewritten
                  next_r.up = next_r.up | r.shift[`CCRB_UP_BIT];
                  next_r.dn = next_r.dn | r.shift[`CCRB_DN_BIT];
                end
              end
              default: ;
            endcase
          end
        end
        CCRB_RDATA: begin
          if (r.bitcnt == `CCRB_BITS_PER_BYTE) begin
            next_r.st = CCRB_RDATA_ACK;
            next_r.sda_oe = 1'b0;
            next_r.ptr = r.ptr + 8'h01;
          end else begin
            next_r.sda_oe = ~r.shift[7];
            next_r.shift = {r.shift[6:0], 1'b0};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
        end
        CCRB_RDATA_ACK: begin
          if (r.nack) begin
            next_r.st = CCRB_IDLE;
          end else begin
            next_r.st = CCRB_RDATA;
            next_r.sda_oe = ~rd_byte[7];
            next_r.shift = {rd_byte[6:0], 1'b0};
            next_r.bitcnt = 4'h1;
          end
        end
        default: ;
      endcase
    end

    // Host timeout counter; kick restarts it and clears itself
    if (r.kick) begin
      next_r.cnt = '0;
      if (!wr_now) begin
        next_r.kick = 1'b0;
      end
    end else if (r.tmr[`CCRB_TMO] == 2'h0) begin
      next_r.cnt = '0;
    end else if (r.cnt >= tmo_limit - `CCRB_CNT_W'(1)) begin
      next_r.cnt = '0;
      next_r.expired = 1'b1;
    end else begin
      next_r.cnt = r.cnt + `CCRB_CNT_W'(1);
    end

    // Defaults restored on software reset or timeout
    if (reg_reset_cmd || next_r.expired) begin
      next_r.cur = `CCRB_RST_CUR;
      next_r.pre = `CCRB_RST_PRE;
      next_r.vlt = `CCRB_RST_VLT;
      next_r.tmr = `CCRB_RST_TMR;
      next_r.up = 1'b0;
      next_r.dn = 1'b0;
      next_r.kick = 1'b0;
      next_r.cnt = '0;
    end
    next_r.chg_en = |next_r.cur[`CCRB_FAST_CHARGE_CURRENT];
  end

  // =====================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_s3 <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_s3 <= 1'b1;
      r.st <= CCRB_IDLE;
      r.cur <= `CCRB_RST_CUR;
      r.pre <= `CCRB_RST_PRE;
      r.vlt <= `CCRB_RST_VLT;
      r.tmr <= `CCRB_RST_TMR;
      r.chg_en <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // =====================================================
  // Outputs
  assign sda_out = 1'b0;
  assign sda_oe = r.sda_oe;
  assign pulse_ctrl_enable = r.cur[`CCRB_PEN_BIT];
  assign fast_charge_current = r.cur[`CCRB_FAST_CHARGE_CURRENT];
  assign charge_enable = r.chg_en;
  assign precharge_current = r.pre[`CCRB_IPRE];
  assign termination_current = r.pre[`CCRB_TERMINATION_CURRENT];
  assign charge_voltage_limit = r.vlt[`CCRB_CHARGE_VOLTAGE_LIMIT];
  assign precharge_to_fast_threshold = r.vlt[`CCRB_LOWV_BIT];
  assign recharge_offset = r.vlt[`CCRB_RECHG_BIT];
  assign termination_enable = r.tmr[`CCRB_TERM_BIT];
  assign status_pin_disable = r.tmr[`CCRB_STDIS_BIT];
  assign host_timeout_sel = r.tmr[`CCRB_TMO];
  assign safety_timer_enable = r.tmr[`CCRB_SAFE_BIT];
  assign fast_charge_time_limit = r.tmr[`CCRB_TLIM];
  assign pulse_voltage_up = r.up;
  assign pulse_voltage_down = r.dn;
  assign timeout_kick = r.kick;
  assign timeout_expired = r.expired;

  // =====================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_fast_charge_current_clamp;
    fast_charge_current <= `CCRB_FAST_CHARGE_CURRENT_MAX;
  endproperty
  a_fast_charge_current_clamp: assert property (p_fast_charge_current_clamp) else $error("fast_charge_current over max");

  property p_charge_voltage_limit_clamp;
    charge_voltage_limit <= `CCRB_CHARGE_VOLTAGE_LIMIT_MAX;
  endproperty
  a_charge_voltage_limit_clamp: assert property (p_charge_voltage_limit_clamp) else $error("charge_voltage_limit over max");

  property p_rsvd;
    r.tmr[`CCRB_RSVD_BIT] && rd_byte[0] == 1'b1 || r.ptr != `CCRB_OFS_TMR;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit not one");

  property p_chg_en;
    charge_enable == (fast_charge_current != 7'h00);
  endproperty
  a_chg_en: assert property (p_chg_en) else $error("charge enable wrong");

  property p_pulse_gate;
    $rose(pulse_voltage_up) || $rose(pulse_voltage_down) |->
      $past(pulse_ctrl_enable);
  endproperty
  a_pulse_gate: assert property (p_pulse_gate) else $error("pulse ungated");

  property p_pulse_done;
    pulse_seq_done && !wr_now |=> !pulse_voltage_up && !pulse_voltage_down;
  endproperty
  a_pulse_done: assert property (p_pulse_done) else $error("pulse stuck");

  property p_kick;
    timeout_kick && !wr_now |=> !timeout_kick && r.cnt == '0;
  endproperty
  a_kick: assert property (p_kick) else $error("kick not cleared");

  property p_sw_reset;
    reg_reset_cmd |=> r.cur == `CCRB_RST_CUR && r.pre == `CCRB_RST_PRE &&
      r.vlt == `CCRB_RST_VLT && r.tmr == `CCRB_RST_TMR;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("no defaults");

  property p_expire;
    timeout_expired |-> r.tmr == `CCRB_RST_TMR && r.cur == `CCRB_RST_CUR &&
      !pulse_voltage_up;
  endproperty
  a_expire: assert property (p_expire) else $error("timeout no defaults");

  property p_tmo_off;
    host_timeout_sel == 2'h0 |=> !timeout_expired;
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("disabled timeout fired");

  c_write: cover property (wr_now && r.ptr == `CCRB_OFS_CUR);
  c_read: cover property (scl_fall && r.st == CCRB_RDATA_ACK && !r.nack);
  c_expire: cover property (timeout_expired);
  c_pulse: cover property ($rose(pulse_voltage_up));
endmodule

// >>> verilog/ccrb_params.svh
// Functional notes
// - Bit 7 enables current-pulse control, default off
// - Fast charge current bits 6:0, default 0100000
// - Fast charge current zero disables charging
// - Fast charge current above 1001111 clamps there
// - Precharge current bits 7:4, default 0001
// - Termination current bits 3:0, default 0011
// - Charge voltage bits 7:2, default 010111
// - Charge voltage above 110000 clamps there
// - Bit 1 picks precharge threshold, default 3.0V
// - Bit 0 picks recharge offset, default 100mV
// - Timer bit 7 enables termination, default on
// - Timer bit 6 disables status pin, default off
// - Timeout field bits 5:4, default 40s
// - Timer bit 3 enables safety timer, default on
// - Time limit bits 2:1, default 12 hours
// - Reserved timer bit 0 reads one
// - Pulse bits settable only when enabled, clear on pulse_seq_done
// - Timeout kick restarts timer, then self-clears
`ifndef CCRB_PARAMS_SVH
`define CCRB_PARAMS_SVH
// =====================================================
// Register map
`define CCRB_OFS_KICK 8'h03
`define CCRB_OFS_CUR 8'h04
`define CCRB_OFS_PRE 8'h05
`define CCRB_OFS_VLT 8'h06
`define CCRB_OFS_TMR 8'h07
`define CCRB_OFS_PULSE 8'h09
`define CCRB_RST_CUR 8'h20
`define CCRB_RST_PRE 8'h13
`define CCRB_RST_VLT 8'h5e
`define CCRB_RST_TMR 8'h9d
// =====================================================
// Field positions and limits
`define CCRB_KICK_BIT 6
`define CCRB_PEN_BIT 7
`define CCRB_FAST_CHARGE_CURRENT 6:0
`define CCRB_FAST_CHARGE_CURRENT_MAX 7'h4f
`define CCRB_IPRE 7:4
`define CCRB_TERMINATION_CURRENT 3:0
`define CCRB_CHARGE_VOLTAGE_LIMIT 7:2
`define CCRB_CHARGE_VOLTAGE_LIMIT_MAX 6'h30
`define CCRB_LOWV_BIT 1
`define CCRB_RECHG_BIT 0
`define CCRB_TERM_BIT 7
`define CCRB_STDIS_BIT 6
`define CCRB_TMO 5:4
`define CCRB_SAFE_BIT 3
`define CCRB_TLIM 2:1
`define CCRB_RSVD_BIT 0
`define CCRB_UP_BIT 1
`define CCRB_DN_BIT 0
// =====================================================
// Timing
`define CCRB_CLK_HZ 100000000
`define CCRB_TMO_BASE_S 40
`define CCRB_CNT_W 40
`define CCRB_BITS_PER_BYTE 4'h8
`endif

// >>> verilog/ccrb_pkg.sv
`include "ccrb_params.svh"
package ccrb_pkg;
  typedef enum logic [3:0] {
    CCRB_IDLE, CCRB_ADDR, CCRB_ADDR_ACK, CCRB_REG, CCRB_REG_ACK,
    CCRB_WDATA, CCRB_WDATA_ACK, CCRB_RDATA, CCRB_RDATA_ACK
  } ccrb_state_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    ccrb_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic [7:0] cur;
    logic [7:0] pre;
    logic [7:0] vlt;
    logic [7:0] tmr;
    logic kick;
    logic up;
    logic dn;
    logic chg_en;
    logic expired;
    logic [`CCRB_CNT_W-1:0] cnt;
  } ccrb_regs_t;
endpackage
